/* File: shared/vfd_map_pkg.sv */
// Constants, register map and power-up map contents of the tube-driver stream mapper.
package vfd_map_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_BLANK_POLARITY = 8'h01;
  localparam logic [7:0] IDX_MAP_PORT = 8'h06;
  localparam logic [7:0] IDX_TEST_MODE = 8'h07;
  localparam logic [7:0] IDX_STREAM_LIMIT = 8'h0e;
  localparam logic [7:0] IDX_MAP_READBACK = 8'h86;
  localparam logic [7:0] IDX_IDENTITY = 8'h87;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int POL_BIT = 1;
  localparam int TEST_BIT = 0;
  localparam int PTR_LOAD_BIT = 7;
  localparam logic POL_RESET = 1'b0;
  localparam logic TEST_RESET = 1'b0;
  localparam logic [6:0] LIMIT_RESET = 7'h53;
  localparam logic [6:0] PTR_RESET = 7'h00;
  localparam logic [7:0] LIMIT_CLAMP_FROM = 8'h54;
  localparam logic [6:0] LIMIT_MAX = 7'h53;
  localparam logic [7:0] PTR_BAD_FROM = 8'hd4;
  localparam logic [6:0] MAP_LAST = 7'h53;
  localparam logic [3:0] TEST_DUTY_CODE = 4'h6;

  // ----------------------------------------------------------------
  // Map entry codes
  // ----------------------------------------------------------------
  localparam logic [6:0] CODE_GRID_LAST = 7'd47;
  localparam logic [6:0] CODE_ROW1_SEG = 7'd48;
  localparam logic [6:0] CODE_ROW2_SEG = 7'd65;
  localparam logic [6:0] CODE_ANNUN = 7'd82;
  localparam logic [6:0] CODE_CURSOR1 = 7'd86;
  localparam logic [6:0] CODE_CURSOR2 = 7'd87;
  localparam logic [6:0] CODE_UNUSED = 7'd88;
  localparam logic [6:0] CODE_NONE = 7'd127;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SHIFT_HALF_NS = 80;
  localparam int SHIFT_HALF_CYCLES = (SHIFT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Power-up map: grids 0..39, both rows of segments, two cursors, spare entries.
  function automatic logic [6:0] default_map(input int idx);
    if (idx < 40) begin
      return 7'(idx);
    end else if (idx < 74) begin
      return 7'(idx + 8);
    end else if (idx == 74) begin
      return CODE_CURSOR1;
    end else if (idx == 75) begin
      return CODE_CURSOR2;
    end
    return CODE_NONE;
  endfunction

endpackage

/* File: verilog/map_code_eval.sv */
// Combinational evaluation of one map entry into one stream bit.
`timescale 1ns/10ps
module map_code_eval
  import vfd_map_pkg::*;
(
  input wire logic [6:0] code_in,
  input wire logic [5:0] grid_in,
  input wire logic two_row_in,
  input wire logic test_in,
  input wire logic [16:0] row1_seg_in,
  input wire logic [16:0] row2_seg_in,
  input wire logic [16:0] seg_exist_in,
  input wire logic [3:0] annun_in,
  input wire logic [1:0] cursor_in,
  output logic bit_out
);

  // ----------------------------------------------------------------
  // Code decode
  // ----------------------------------------------------------------
  // Invalid, unused and absent-segment codes all fall to zero, so the tube
  // never sees a stray lit element from a badly loaded map.
  always_comb begin
    logic [6:0] seg1;
    logic [6:0] seg2;
    seg1 = 7'(code_in - CODE_ROW1_SEG);
    seg2 = 7'(code_in - CODE_ROW2_SEG);
    bit_out = 1'b0;
    if (code_in <= CODE_GRID_LAST) begin
      bit_out = (code_in[5:0] == grid_in);
    end else if (code_in < CODE_ROW2_SEG) begin
      bit_out = seg_exist_in[seg1[4:0]] & (test_in | row1_seg_in[seg1[4:0]]);
    end else if (code_in < CODE_ANNUN) begin
      bit_out = two_row_in & seg_exist_in[seg2[4:0]] &
                (test_in | row2_seg_in[seg2[4:0]]);
    end else if (code_in < CODE_CURSOR1) begin
      bit_out = ~two_row_in & (test_in | annun_in[code_in[1:0] - 2'd2]);
    end else if (code_in == CODE_CURSOR1) begin
      bit_out = test_in | cursor_in[0];
    end else if (code_in == CODE_CURSOR2) begin
      bit_out = two_row_in & (test_in | cursor_in[1]);
    end
    // Codes from CODE_UNUSED upward stay low.
  end

endmodule

/* File: verilog/vfd_output_bit_mapper.sv */
// Output map, control registers and serial stream engine for a shift-register tube driver.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps

module vfd_output_bit_mapper
  import vfd_map_pkg::*;
#(
  parameter int MAP_DEPTH = 84,
  parameter int HALF_CYCLES = SHIFT_HALF_CYCLES,
  parameter logic [6:0] PART_ID = 7'h5a // Value is arbitrary.
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic FRAME_START_IN,
  input wire logic [5:0] NEXT_GRID_IN,
  input wire logic TWO_ROW_IN,
  input wire logic [16:0] ROW1_SEG_IN,
  input wire logic [16:0] ROW2_SEG_IN,
  input wire logic [16:0] SEG_EXIST_IN,
  input wire logic [3:0] ANNUN_IN,
  input wire logic [1:0] CURSOR_IN,
  input wire logic BLANK_REQ_IN,
  input wire logic [3:0] INTENSITY_IN,
  output logic DRIVER_GATE_OUT,
  output logic DRIVER_SHIFT_CLOCK_OUT,
  output logic DRIVER_SERIAL_OUT,
  output logic DRIVER_LATCH_LOAD_OUT,
  output logic [3:0] DUTY_CODE_OUT,
  output logic STREAM_BUSY_OUT
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (MAP_DEPTH < 1 || MAP_DEPTH > int'(MAP_LAST) + 1) begin : g_bad_depth
    $error("MAP_DEPTH must lie between 1 and 84");
  end
  if (HALF_CYCLES < 1 || HALF_CYCLES > 255) begin : g_bad_half
    $error("HALF_CYCLES must lie between 1 and 255");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_LOAD = 2'b10
  } stream_state_t;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic pol;
  logic test;
  logic [6:0] limit;
  logic [6:0] ptr;
  logic map_full;
  logic [6:0] map_mem [MAP_DEPTH];
  logic [7:0] idx;
  logic aligned;
  logic setup;
  logic commit;
  logic wr_ok;
  logic rd_ok;
  logic wr_lane;
  logic [7:0] wbyte;
  logic map_wr;
  logic map_rd;
  logic ptr_ld;

  assign idx = PADDR_IN[9:2];
  assign aligned = (PADDR_IN[1:0] == 2'b00) && (PADDR_IN[11:10] == 2'b00);
  assign setup = PSEL_IN && !PENABLE_IN;
  assign commit = PSEL_IN && PENABLE_IN && PREADY_OUT;
  assign wbyte = PWDATA_IN[7:0];
  assign wr_lane = PSTRB_IN[0];
  assign wr_ok = aligned && (idx == IDX_BLANK_POLARITY || idx == IDX_MAP_PORT ||
                             idx == IDX_TEST_MODE || idx == IDX_STREAM_LIMIT);
  assign rd_ok = aligned && (idx == IDX_BLANK_POLARITY || idx == IDX_STREAM_LIMIT ||
                             idx == IDX_MAP_READBACK || idx == IDX_IDENTITY);
  assign map_wr = commit && PWRITE_IN && wr_lane && aligned && idx == IDX_MAP_PORT;
  assign map_rd = commit && !PWRITE_IN && aligned && idx == IDX_MAP_READBACK;
  assign ptr_ld = map_wr && wbyte[PTR_LOAD_BIT];

  // Zero-wait slave: ready and the error flag are set in the setup cycle, so
  // every access phase completes in exactly one cycle.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= setup;
      PSLVERR_OUT <= setup && (PWRITE_IN ? !wr_ok : !rd_ok);
    end
  end

  // Read data is captured in the setup cycle; the pointer cannot move between
  // setup and access, so the entry shown is the one the access consumes.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (setup && !PWRITE_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
      if (aligned) begin
        unique case (idx)
          IDX_BLANK_POLARITY: PRDATA_OUT[POL_BIT] <= pol;
          IDX_STREAM_LIMIT: PRDATA_OUT[6:0] <= limit;
          IDX_MAP_READBACK: PRDATA_OUT[6:0] <= map_mem[ptr];
          IDX_IDENTITY: PRDATA_OUT[7:0] <= {PART_ID, test};
          default: PRDATA_OUT <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Oversized limits clamp instead of wrapping, so the stream never runs
  // past the last map entry.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      pol <= POL_RESET;
      test <= TEST_RESET;
      limit <= LIMIT_RESET;
    end else if (commit && PWRITE_IN && wr_lane && aligned) begin
      if (idx == IDX_BLANK_POLARITY) begin
        pol <= wbyte[POL_BIT];
      end
      if (idx == IDX_TEST_MODE) begin
        test <= wbyte[TEST_BIT];
      end
      if (idx == IDX_STREAM_LIMIT) begin
        limit <= (wbyte >= LIMIT_CLAMP_FROM) ? LIMIT_MAX : wbyte[6:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Map pointer and storage
  // ----------------------------------------------------------------
  // The pointer is never readable; reads and data writes both advance it.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      ptr <= PTR_RESET;
      map_full <= 1'b0;
    end else if (ptr_ld) begin
      ptr <= (wbyte >= PTR_BAD_FROM) ? PTR_RESET : wbyte[6:0];
      map_full <= 1'b0;
    end else if ((map_wr || map_rd) && !map_full) begin
      if (ptr == MAP_LAST) begin
        map_full <= 1'b1;
      end else begin
        ptr <= ptr + 7'd1;
      end
    end
  end

  // Defaults are loaded by reset, so an unconfigured part already drives a
  // forty-digit tube.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i < MAP_DEPTH; i++) begin
        map_mem[i] <= default_map(i);
      end
    end else if (map_wr && !wbyte[PTR_LOAD_BIT] && !map_full) begin
      map_mem[ptr] <= wbyte[6:0];
    end
  end

  // ----------------------------------------------------------------
  // Blanking and duty outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      DRIVER_GATE_OUT <= ~POL_RESET;
      DUTY_CODE_OUT <= 4'h0;
    end else begin
      DRIVER_GATE_OUT <= BLANK_REQ_IN ^ pol;
      DUTY_CODE_OUT <= test ? TEST_DUTY_CODE : INTENSITY_IN;
    end
  end

  // ----------------------------------------------------------------
  // Stream engine
  // ----------------------------------------------------------------
  stream_state_t state;
  logic [7:0] half_cnt;
  logic half_tick;
  logic [6:0] bit_idx;
  logic [5:0] grid;
  logic two_row;
  logic [16:0] row1;
  logic [16:0] row2;
  logic [16:0] exist;
  logic [3:0] annun;
  logic [1:0] cursor;
  logic [6:0] cur_code;
  logic eval_bit;

  assign half_tick = (state != ST_IDLE) && (half_cnt == 8'(HALF_CYCLES - 1));
  assign cur_code = map_mem[bit_idx];

  // Divider producing the half-period enable of the outgoing shift clock.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN || state == ST_IDLE || half_tick) begin
      half_cnt <= 8'h00;
    end else begin
      half_cnt <= half_cnt + 8'h01;
    end
  end

  // Display data for the next grid is frozen at the frame start so that a
  // scheduler changing it mid-stream cannot tear the pattern.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      grid <= 6'h00;
      two_row <= 1'b0;
      row1 <= 17'h0_0000;
      row2 <= 17'h0_0000;
      exist <= 17'h0_0000;
      annun <= 4'h0;
      cursor <= 2'b00;
    end else if (state == ST_IDLE && FRAME_START_IN) begin
      grid <= NEXT_GRID_IN;
      two_row <= TWO_ROW_IN;
      row1 <= ROW1_SEG_IN;
      row2 <= ROW2_SEG_IN;
      exist <= SEG_EXIST_IN;
      annun <= ANNUN_IN;
      cursor <= CURSOR_IN;
    end
  end

  map_code_eval u_eval (
    .code_in(cur_code),
    .grid_in(grid),
    .two_row_in(two_row),
    .test_in(test),
    .row1_seg_in(row1),
    .row2_seg_in(row2),
    .seg_exist_in(exist),
    .annun_in(annun),
    .cursor_in(cursor),
    .bit_out(eval_bit)
  );

  // Clock idles high; each bit goes out on a falling half and is held over
  // the following rising half, where the driver samples it.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      state <= ST_IDLE;
      bit_idx <= 7'h00;
      DRIVER_SHIFT_CLOCK_OUT <= 1'b1;
      DRIVER_SERIAL_OUT <= 1'b0;
      DRIVER_LATCH_LOAD_OUT <= 1'b0;
      STREAM_BUSY_OUT <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (FRAME_START_IN) begin
            state <= ST_SHIFT;
            bit_idx <= 7'h00;
            STREAM_BUSY_OUT <= 1'b1;
          end
        end
        ST_SHIFT: begin
          if (half_tick && DRIVER_SHIFT_CLOCK_OUT) begin
            DRIVER_SHIFT_CLOCK_OUT <= 1'b0;
            DRIVER_SERIAL_OUT <= eval_bit;
          end else if (half_tick) begin
            DRIVER_SHIFT_CLOCK_OUT <= 1'b1;
            if (bit_idx >= limit || int'(bit_idx) == MAP_DEPTH - 1) begin
              state <= ST_LOAD;
              DRIVER_LATCH_LOAD_OUT <= 1'b1;
            end else begin
              bit_idx <= bit_idx + 7'd1;
            end
          end
        end
        ST_LOAD: begin
          if (half_tick) begin
            state <= ST_IDLE;
            DRIVER_LATCH_LOAD_OUT <= 1'b0;
            STREAM_BUSY_OUT <= 1'b0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  logic [7:0] fall_cnt;
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN || (state == ST_IDLE && FRAME_START_IN)) begin
      fall_cnt <= 8'h00;
    end else if ($fell(DRIVER_SHIFT_CLOCK_OUT)) begin
      fall_cnt <= fall_cnt + 8'h01;
    end
  end

  chk_gate_polarity: assert property (
    $changed(pol) |=> ##1 (DRIVER_GATE_OUT == ($past(BLANK_REQ_IN) ^ pol)))
    else $error("Gate level does not follow polarity select");
  chk_test_duty: assert property (
    test && $past(test) |-> DUTY_CODE_OUT == TEST_DUTY_CODE)
    else $error("Test mode did not force seven sixteenths duty");
  chk_identity_read: assert property (
    commit && !PWRITE_IN && aligned && idx == IDX_IDENTITY |->
      PRDATA_OUT[7:0] == {PART_ID, test} && PRDATA_OUT[31:8] == 24'h00_0000)
    else $error("Identity read returned wrong value");
  chk_limit_clamp: assert property (
    commit && PWRITE_IN && wr_lane && aligned && idx == IDX_STREAM_LIMIT &&
      wbyte >= LIMIT_CLAMP_FROM |=> limit == LIMIT_MAX)
    else $error("Oversized stream limit not clamped");
  chk_pointer_load: assert property (
    ptr_ld |=> ptr == (($past(wbyte) >= PTR_BAD_FROM) ? PTR_RESET : $past(wbyte[6:0])) &&
      !map_full)
    else $error("Pointer load gave wrong entry");
  chk_pointer_step: assert property (
    (map_wr || map_rd) && !ptr_ld && !map_full && ptr != MAP_LAST |=>
      ptr == $past(ptr) + 7'd1)
    else $error("Pointer did not advance by one");
  chk_full_ignore: assert property (
    map_full && map_wr && !ptr_ld |=> map_mem[ptr] == $past(map_mem[ptr]) && map_full)
    else $error("Map write accepted after last entry");
  chk_stream_length: assert property (
    $rose(DRIVER_LATCH_LOAD_OUT) |-> fall_cnt == 8'(limit) + 8'h01)
    else $error("Stream length differs from limit plus one");
  chk_data_on_fall: assert property (
    $changed(DRIVER_SERIAL_OUT) |-> $fell(DRIVER_SHIFT_CLOCK_OUT))
    else $error("Serial data moved away from a falling edge");
  chk_unused_low: assert property (
    state == ST_SHIFT && half_tick && DRIVER_SHIFT_CLOCK_OUT && cur_code >= CODE_UNUSED |=>
      !DRIVER_SERIAL_OUT)
    else $error("Unused map code drove a high bit");

  cov_frame_done: cover property ($fell(STREAM_BUSY_OUT));
  cov_pointer_reload: cover property (map_full ##[1:50] ptr_ld);
  cov_identity_read: cover property (commit && !PWRITE_IN && idx == IDX_IDENTITY);
  cov_limit_clamp: cover property (commit && PWRITE_IN && idx == IDX_STREAM_LIMIT &&
    wbyte >= LIMIT_CLAMP_FROM);

endmodule

/* File: testbench/tube_driver_model.sv */
// Behavioural shift-register tube driver that captures the serial stream from the mapper.
`timescale 1ns/10ps
module tube_driver_model (
  input wire logic shift_clock_in,
  input wire logic serial_in,
  input wire logic latch_load_in,
  output logic [83:0] latched_out,
  output logic [6:0] count_out
);
  // ----------------------------------------------------------------
  // Shift register and output latch
  // ----------------------------------------------------------------
  logic [83:0] shifter = '0;
  logic [6:0] idx = '0;
  logic [6:0] start = '0;
  logic armed = 1'b0;

  initial begin
    latched_out = '0;
    count_out = '0;
  end

  // The shift clock leaves reset with a step from unknown to high, which is no real edge.
  // Bits are only taken once a true falling edge has been seen.
  always @(negedge shift_clock_in) begin
    armed <= 1'b1;
  end

  // Data is taken on the rising shift clock edge, after it settled on the falling one.
  // The bit counter runs freely; each frame is measured from where the last latch left it.
  always @(posedge shift_clock_in) begin
    if (armed) begin
      shifter[7'(idx - start)] <= serial_in;
      idx <= idx + 7'd1;
    end
  end

  // The latch is transparent while load is high, so it keeps what it sees as load falls.
  // Latching on the fall also avoids racing the last shift edge, which shares the load rise.
  always @(negedge latch_load_in) begin
    latched_out <= shifter;
    count_out <= 7'(idx - start);
    start <= idx;
  end
endmodule

/* File: testbench/test_vfd_output_bit_mapper.sv */
// Self-checking bench for the tube-driver stream mapper.
`timescale 1ns/10ps
module test_vfd_output_bit_mapper;
  import vfd_map_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [6:0] ID = 7'h33; // Value is arbitrary.
  localparam int LIMIT = 6000;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, frame = 0, two_row = 0, blank = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf, intensity = 4'h9, annun = 4'h1, duty;
  logic [5:0] grid = 6'd5;
  logic [16:0] row1 = 17'h10003, row2 = 17'h00001, exist = 17'h1fffd;
  logic [1:0] cursor = 2'b11;
  logic pready, pslverr, gate, sclk, sdata, load, busy, err;
  logic [83:0] latched;
  logic [6:0] nbits;
  logic [6:0] codes [12] = '{7'd5, 7'd6, 7'd48, 7'd49, 7'd64, 7'd65, 7'd82, 7'd83, 7'd86,
    7'd87, 7'd100, 7'd127};
  int error_cnt = 0, compares = 0, cyc = 0;

  vfd_output_bit_mapper #(.HALF_CYCLES(4), .PART_ID(ID)) uut (
    .CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .FRAME_START_IN(frame), .NEXT_GRID_IN(grid),
    .TWO_ROW_IN(two_row), .ROW1_SEG_IN(row1), .ROW2_SEG_IN(row2), .SEG_EXIST_IN(exist),
    .ANNUN_IN(annun), .CURSOR_IN(cursor), .BLANK_REQ_IN(blank), .INTENSITY_IN(intensity),
    .DRIVER_GATE_OUT(gate), .DRIVER_SHIFT_CLOCK_OUT(sclk), .DRIVER_SERIAL_OUT(sdata),
    .DRIVER_LATCH_LOAD_OUT(load), .DUTY_CODE_OUT(duty), .STREAM_BUSY_OUT(busy));

  tube_driver_model model (.shift_clock_in(sclk), .serial_in(sdata), .latch_load_in(load),
    .latched_out(latched), .count_out(nbits));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial forever #10 clk = ~clk;

  // A hung handshake or stream ends the run here rather than running forever.
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the answer is sampled at the edge where pready is seen high.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    // No wait count is assumed; a slave that never answers is caught by the run timeout.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Expected power-up map contents, worked out independently of the design.
  function automatic logic [31:0] dflt(input int i);
    return 32'((i < 40) ? i : (i < 74) ? i + 8 : (i < 76) ? i + 12 : 127);
  endfunction

  // Sends one frame and compares what the driver model latched.
  task automatic run(input logic [11:0] exp);
    @(posedge clk);
    frame <= 1;
    @(posedge clk);
    frame <= 0;
    @(posedge clk);
    while (busy !== 1'b0) begin
      @(posedge clk);
    end
    check(latched[11:0], exp);
    check(nbits, 12);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    rd_chk(12'h038, 32'h53);
    rd_chk(12'h21c, {24'h0, ID, 1'b0});
    // Read the whole power-up map from entry zero; the pointer then rests on the last entry.
    for (int i = 0; i < 84; i++) rd_chk(12'h218, dflt(i));
    rd_chk(12'h218, 32'd127);
    // Load a new map and read it back.
    wr(12'h018, 32'h80);
    for (int i = 0; i < 12; i++) wr(12'h018, 32'(codes[i]));
    wr(12'h018, 32'h80);
    for (int i = 0; i < 12; i++) rd_chk(12'h218, 32'(codes[i]));
    // Writes beyond the last entry are dropped until the pointer is loaded again.
    wr(12'h018, 32'hd3);
    wr(12'h018, 32'h11);
    wr(12'h018, 32'h22);
    wr(12'h018, 32'hd3);
    rd_chk(12'h218, 32'h11);
    wr(12'h018, 32'hd4);
    rd_chk(12'h218, 32'd5);
    wr(12'h018, 32'h85);
    rd_chk(12'h218, 32'd65);
    // Stream length clamps at the top of its range.
    wr(12'h038, 32'h54);
    rd_chk(12'h038, 32'h53);
    wr(12'h038, 32'hff);
    rd_chk(12'h038, 32'h53);
    wr(12'h038, 32'h0b);
    rd_chk(12'h038, 32'h0b);
    // A write without its low byte lane enabled leaves the register alone.
    pstrb <= 4'h0;
    wr(12'h038, 32'h20);
    pstrb <= 4'hf;
    rd_chk(12'h038, 32'h0b);
    // Pointer readback, wrong-direction and unmapped-address accesses are refused.
    xfer(1'b0, 12'h018, 32'h0);
    check(err, 1);
    xfer(1'b1, 12'h218, 32'h5);
    check(err, 1);
    xfer(1'b0, 12'h010, 32'h0);
    check(err, 1);
    // Blanking level follows the polarity bit.
    check(gate, 0);
    wr(12'h004, 32'h02);
    rd_chk(12'h004, 32'h02);
    blank <= 1;
    repeat (2) @(posedge clk);
    check(gate, 0);
    blank <= 0;
    repeat (2) @(posedge clk);
    check(gate, 1);
    wr(12'h004, 32'h00);
    // Frames in both layouts, then in test mode.
    run(12'h155);
    two_row <= 1;
    run(12'h335);
    two_row <= 0;
    wr(12'h01c, 32'h01);
    rd_chk(12'h21c, {24'h0, ID, 1'b1});
    repeat (2) @(posedge clk);
    check(duty, 32'(TEST_DUTY_CODE));
    run(12'h1d5);
    wr(12'h01c, 32'h00);
    repeat (2) @(posedge clk);
    check(duty, 32'h9);
    final_report();
  end
endmodule
